// file: hdl/port_csr_map.svh
// register indices, field positions and reset values of the port csr pair
`ifndef PORT_CSR_MAP_SVH
`define PORT_CSR_MAP_SVH
`define CSR_IDX_PORT_A 1'b0
`define CSR_IDX_PORT_B 1'b1
`define CSR_WIDTH 16
`define CSR_LOW_BYTE_MSB 7
`define CSR_DIR_BIT 8
`define CSR_IE_BIT 9
`define CSR_RDY_BIT 15
`define CSR_DIR_RESET 1'b0
`define CSR_IE_RESET 1'b0
`define CSR_BE_LOW 0
`define CSR_BE_HIGH 1
`define REQ_LINES_DEFAULT 16
`endif

// file: hdl/port_csr_pkg.sv
// types shared by the port csr block
package port_csr_pkg;
  // one host access to the csr pair
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } host_req_s;

  // strobes and write byte toward the group 1 interrupt controller
  typedef struct packed {
    logic cmd_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } ctl_req_s;

  typedef enum logic [0:0] {
    ACC_IDLE = 1'b0,
    ACC_FETCH = 1'b1
  } acc_state_e;
endpackage : port_csr_pkg

// file: hdl/port_csr_group1.sv
// control/status register pair for ports a and b with group 1 access
//
// What this block does
// - Sixteen request lines are watched, each may raise its own vector.
// - Port a low byte reads controller status; a write passes a command.
// - Port b low byte accesses the register picked by the last command.
// - Bus initialize leaves both low bytes untouched.
// - Bit 8 of each register steers only that port's own buffer direction.
// - A zero direction bit asserts the ready output; the block is input side.
// - Port data is driven only while direction is one and user ready is set.
// - If direction or user ready is negated, the port data stays released.
// - Bus initialize clears both direction bits.
// - Bit 9 of the port a register gates processor interrupts of both groups.
// - Bit 15 of each register reads the two-flop synchronised user ready level of its port.
// - Bus initialize does not alter the user ready status bit.
// - Both registers are reachable by byte and by word.
`timescale 1ns/1ps
`include "port_csr_map.svh"

module port_csr_group1 #(
  parameter int REQ_LINES = `REQ_LINES_DEFAULT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic bus_initialize,
  // host register access
  input wire port_csr_pkg::host_req_s host_req,
  output logic host_busy,
  output logic host_ack,
  output logic [15:0] host_rdata,
  // group 1 interrupt controller side
  output port_csr_pkg::ctl_req_s ctl_req,
  input wire logic [7:0] ctl_status,
  input wire logic [7:0] ctl_rdata,
  input wire logic grp1_irq_req,
  input wire logic grp2_irq_req,
  output logic proc_irq_req,
  // external request lines
  input wire logic [REQ_LINES-1:0] ext_req,
  output logic [REQ_LINES-1:0] ext_req_sync,
  // port a pins
  input wire logic user_ready_a,
  output logic interface_ready_output_a,
  input wire logic [15:0] port_a_data_buffer,
  output logic [15:0] port_a_data_out,
  output logic port_a_data_oe_n,
  // port b pins
  input wire logic user_ready_b,
  output logic interface_ready_output_b,
  input wire logic [15:0] port_b_data_buffer,
  output logic [15:0] port_b_data_out,
  output logic port_b_data_oe_n
);

  // the two groups of eight need an even, non-empty line count; anything
  // else could not be split evenly between the two controllers
  if (REQ_LINES < 2 || (REQ_LINES % 2) != 0) begin : g_bad_req_lines
    $error("REQ_LINES must be even and at least 2");
  end

  // access sequencer
  port_csr_pkg::acc_state_e state_reg;
  logic fetch_addr_reg;

  // two-flop synchronisers for the control inputs that come from pins
  // (bus initialize, user ready and the request lines)
  logic init_meta_reg;
  logic init_sync_reg;
  logic rdy_a_meta_reg;
  logic rdy_a_sync_reg;
  logic rdy_b_meta_reg;
  logic rdy_b_sync_reg;
  logic [REQ_LINES-1:0] req_meta_reg;
  logic [REQ_LINES-1:0] req_sync_reg;

  // the only csr bits that live in this block; the low bytes belong
  // to the controller
  logic dir_a_reg;
  logic dir_b_reg;
  logic ie_reg;

  // host answer
  logic ack_reg;
  logic [15:0] rdata_reg;

  // strobes and byte toward the group 1 controller
  logic ctl_cmd_wr_reg;
  logic ctl_data_wr_reg;
  logic ctl_data_rd_reg;
  logic [7:0] ctl_wdata_reg;

  // registered pin drivers
  logic [15:0] a_out_reg;
  logic [15:0] b_out_reg;
  logic a_oe_n_reg;
  logic b_oe_n_reg;

  // decoded host access terms
  logic take_wr;
  logic take_rd;
  logic wr_low;
  logic wr_high;

  // read views of the two registers
  logic [15:0] csr_a_view;
  logic [15:0] csr_b_view;

  // bus initialize and user ready arrive from pins, so two flops first;
  // the first flop may go metastable, so only the second is ever read,
  // at the cost of two cycles of lag on every pin-driven bit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      init_meta_reg <= 1'b0;
      init_sync_reg <= 1'b0;
      rdy_a_meta_reg <= 1'b0;
      rdy_a_sync_reg <= 1'b0;
      rdy_b_meta_reg <= 1'b0;
      rdy_b_sync_reg <= 1'b0;
    end else begin
      init_meta_reg <= bus_initialize;
      init_sync_reg <= init_meta_reg;
      rdy_a_meta_reg <= user_ready_a;
      rdy_a_sync_reg <= rdy_a_meta_reg;
      rdy_b_meta_reg <= user_ready_b;
      rdy_b_sync_reg <= rdy_b_meta_reg;
    end
  end

  // request lines are synchronised once here for both controllers,
  // so the two groups never see one line change in different cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_meta_reg <= '0;
      req_sync_reg <= '0;
    end else begin
      req_meta_reg <= ext_req;
      req_sync_reg <= req_meta_reg;
    end
  end

  // handed on already two flops deep
  assign ext_req_sync = req_sync_reg;

  // a request is taken only in idle; a fetch cycle makes the host wait,
  // and a request held through busy is taken once the fetch has ended
  assign host_busy = (state_reg == port_csr_pkg::ACC_FETCH);
  assign take_wr = host_req.sel && host_req.wr && !host_busy;
  assign take_rd = host_req.sel && host_req.rd && !host_req.wr && !host_busy;
  assign wr_low = take_wr && host_req.be[`CSR_BE_LOW];
  assign wr_high = take_wr && host_req.be[`CSR_BE_HIGH];

  // access sequencer: reads spend one cycle letting the controller answer;
  // the fetch cycle gives the controller a whole clock to present its
  // data byte after the read strobe, while writes need no such wait
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= port_csr_pkg::ACC_IDLE;
      fetch_addr_reg <= 1'b0;
    end else begin
      case (state_reg)
        port_csr_pkg::ACC_IDLE: begin
          if (take_rd) begin
            state_reg <= port_csr_pkg::ACC_FETCH;
            fetch_addr_reg <= host_req.addr;
          end
        end
        port_csr_pkg::ACC_FETCH: begin
          state_reg <= port_csr_pkg::ACC_IDLE;
        end
        default: begin
          state_reg <= port_csr_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  // direction and enable bits; bus initialize wins over a host write,
  // since the clear must stick even when software writes in that cycle;
  // the synchronised init is used so a pin glitch cannot half-clear them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dir_a_reg <= `CSR_DIR_RESET;
      dir_b_reg <= `CSR_DIR_RESET;
      ie_reg <= `CSR_IE_RESET;
    end else if (init_sync_reg) begin
      dir_a_reg <= `CSR_DIR_RESET;
      dir_b_reg <= `CSR_DIR_RESET;
      ie_reg <= `CSR_IE_RESET;
    end else if (wr_high) begin
      // bits 10..15 of a and 9..15 of b have no storage at all
      if (host_req.addr == `CSR_IDX_PORT_A) begin
        dir_a_reg <= host_req.wdata[`CSR_DIR_BIT];
        ie_reg <= host_req.wdata[`CSR_IE_BIT];
      end else begin
        dir_b_reg <= host_req.wdata[`CSR_DIR_BIT];
      end
    end
  end

  // low byte writes go straight to the controller as one-cycle strobes;
  // the byte is kept after the strobe, so a late controller still sees it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_cmd_wr_reg <= 1'b0;
      ctl_data_wr_reg <= 1'b0;
      ctl_data_rd_reg <= 1'b0;
      ctl_wdata_reg <= 8'h00;
    end else begin
      ctl_cmd_wr_reg <= wr_low && (host_req.addr == `CSR_IDX_PORT_A);
      ctl_data_wr_reg <= wr_low && (host_req.addr == `CSR_IDX_PORT_B);
      // reading the data byte may have side effects, so flag it once
      ctl_data_rd_reg <= take_rd &&
                         (host_req.addr == `CSR_IDX_PORT_B);
      if (wr_low) begin
        ctl_wdata_reg <= host_req.wdata[`CSR_LOW_BYTE_MSB:0];
      end
    end
  end

  // the low bytes are never held here, so bus initialize cannot touch them;
  // strobes leave on flops, so the controller sees clean one-cycle pulses
  assign ctl_req.cmd_wr = ctl_cmd_wr_reg;
  assign ctl_req.data_wr = ctl_data_wr_reg;
  assign ctl_req.data_rd = ctl_data_rd_reg;
  assign ctl_req.wdata = ctl_wdata_reg;

  // read views; unused bits are constant zero
  // they are tied low rather than stored, so writes to them vanish;
  // built every cycle, only the fetch cycle copies one of them out
  always_comb begin
    csr_a_view = '0;
    csr_a_view[`CSR_LOW_BYTE_MSB:0] = ctl_status;
    csr_a_view[`CSR_DIR_BIT] = dir_a_reg;
    csr_a_view[`CSR_IE_BIT] = ie_reg;
    csr_a_view[`CSR_RDY_BIT] = rdy_a_sync_reg;
    csr_b_view = '0;
    csr_b_view[`CSR_LOW_BYTE_MSB:0] = ctl_rdata;
    csr_b_view[`CSR_DIR_BIT] = dir_b_reg;
    csr_b_view[`CSR_RDY_BIT] = rdy_b_sync_reg;
  end

  // answer: writes ack the cycle after, reads after the fetch cycle;
  // rdata is left alone after the ack so a slow reader can still take it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      ack_reg <= take_wr || (state_reg == port_csr_pkg::ACC_FETCH);
      if (state_reg == port_csr_pkg::ACC_FETCH) begin
        // whole word returned; a byte reader picks its lane
        rdata_reg <= (fetch_addr_reg == `CSR_IDX_PORT_A) ?
                     csr_a_view : csr_b_view;
      end
    end
  end

  // answer straight from its flops
  assign host_ack = ack_reg;
  assign host_rdata = rdata_reg;

  // processor request from either group is gated by the global enable;
  // combinational so clearing the enable drops the request at once
  always_comb begin
    proc_irq_req = ie_reg && (grp1_irq_req || grp2_irq_req);
  end

  // ready output says the block is the input side
  // it follows the stored bit only; user ready plays no part here
  assign interface_ready_output_a = !dir_a_reg;
  assign interface_ready_output_b = !dir_b_reg;

  // pin drivers; user ready is the user's own request to be fed data
  // data and enable are both registered so they change in one cycle
  // and the pins never show a half-updated word
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a_out_reg <= 16'h0000;
      b_out_reg <= 16'h0000;
      a_oe_n_reg <= 1'b1;
      b_oe_n_reg <= 1'b1;
    end else begin
      a_out_reg <= port_a_data_buffer;
      b_out_reg <= port_b_data_buffer;
      a_oe_n_reg <= !(dir_a_reg && rdy_a_sync_reg);
      b_oe_n_reg <= !(dir_b_reg && rdy_b_sync_reg);
    end
  end

  // pins straight from the driver flops
  assign port_a_data_out = a_out_reg;
  assign port_b_data_out = b_out_reg;
  assign port_a_data_oe_n = a_oe_n_reg;
  assign port_b_data_oe_n = b_oe_n_reg;

endmodule : port_csr_group1

// file: verif/port_csr_group1_sva.sv
// checker for the port csr pair, bound to the design top
`timescale 1ns/1ps
module port_csr_group1_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic bus_initialize,
  // host side
  input wire port_csr_pkg::host_req_s host_req,
  input wire logic host_busy,
  input wire logic host_ack,
  input wire logic [15:0] host_rdata,
  // controller and pins
  input wire port_csr_pkg::ctl_req_s ctl_req,
  input wire logic grp1_irq_req,
  input wire logic grp2_irq_req,
  input wire logic proc_irq_req,
  input wire logic user_ready_b,
  input wire logic interface_ready_output_a,
  input wire logic interface_ready_output_b,
  input wire logic port_b_data_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic tw;
  // a request the design accepts this edge
  assign take = host_req.sel && (host_req.wr || host_req.rd) && !host_busy;
  assign tw = take && host_req.wr;

  AST_WR_ACK:
  assert property (tw |=> host_ack && !host_busy)
    else $error("write not answered next cycle");
  AST_RD_ACK:
  assert property (take && !host_req.wr |=>
    host_busy && !host_ack ##1 host_ack)
    else $error("read answer out of step");
  AST_CMD:
  assert property (tw && !host_req.addr && host_req.be[0] |=> ctl_req.cmd_wr
    && !ctl_req.data_wr && ctl_req.wdata == $past(host_req.wdata[7:0]))
    else $error("command byte not passed on");
  AST_DWR:
  assert property (tw && host_req.addr && host_req.be[0] |=> ctl_req.data_wr
    && !ctl_req.cmd_wr)
    else $error("data byte write not passed on");
  AST_DRD:
  assert property (take && !host_req.wr && host_req.addr |=> ctl_req.data_rd)
    else $error("data byte read strobe missing");
  AST_HI_ONLY:
  assert property (tw && !host_req.be[0] |=> !ctl_req.cmd_wr
    && !ctl_req.data_wr)
    else $error("high byte write touched controller");
  AST_PAD:
  assert property (host_ack && $past(host_busy) |-> host_rdata[14:10] == 5'h00)
    else $error("unused bits read nonzero");
  AST_OE_B:
  assert property (!$past(user_ready_b, 3) |-> port_b_data_oe_n)
    else $error("port b driven without user ready");
  AST_IRQ:
  assert property (!grp1_irq_req && !grp2_irq_req |-> !proc_irq_req)
    else $error("interrupt without a group request");
  AST_INIT:
  assert property (bus_initialize [*4] |=> !proc_irq_req
    && interface_ready_output_a && interface_ready_output_b)
    else $error("bus initialize left direction or enable set");
endmodule : port_csr_group1_sva

// file: verif/group1_ctl_model.sv
// group 1 interrupt controller stand-in behind the csr pair
`timescale 1ns/1ps
module group1_ctl_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // csr side
  input wire port_csr_pkg::ctl_req_s ctl_req,
  output logic [7:0] ctl_status,
  output logic [7:0] ctl_rdata
);
  logic [7:0] cmd_reg;
  logic [7:0] mem_reg [8];
  // last command kept; status echoes it so the read path is visible
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cmd_reg <= 8'h00;
    else if (ctl_req.cmd_wr) cmd_reg <= ctl_req.wdata;
  end
  // internal register picked by the last command
  always_ff @(posedge mclk) begin
    if (ctl_req.data_wr) mem_reg[cmd_reg[2:0]] <= ctl_req.wdata;
  end
  assign ctl_status = cmd_reg;
  assign ctl_rdata = mem_reg[cmd_reg[2:0]];
endmodule : group1_ctl_model

// file: verif/testbench.sv
// self-checking bench for the port csr pair
`timescale 1ns/1ps
module testbench;
  port_csr_pkg::host_req_s host_req;
  port_csr_pkg::ctl_req_s ctl_req;
  logic [7:0] ctl_status, ctl_rdata;
  logic [15:0] host_rdata, ext_req, ext_req_sync;
  logic [15:0] port_a_data_buffer, port_a_data_out;
  logic [15:0] port_b_data_buffer, port_b_data_out;
  logic mclk, rst_n, bus_initialize, host_busy, host_ack, proc_irq_req;
  logic grp1_irq_req, grp2_irq_req, user_ready_a, user_ready_b;
  logic interface_ready_output_a, interface_ready_output_b;
  logic port_a_data_oe_n, port_b_data_oe_n;
  int miscompares;
  int checked;
  // design and controller stand-in
  port_csr_group1 #(.REQ_LINES(16)) dut_u (.mclk, .rst_n, .bus_initialize,
    .host_req, .host_busy, .host_ack, .host_rdata, .ctl_req, .ctl_status,
    .ctl_rdata, .grp1_irq_req, .grp2_irq_req, .proc_irq_req, .ext_req,
    .ext_req_sync, .user_ready_a, .interface_ready_output_a,
    .port_a_data_buffer, .port_a_data_out, .port_a_data_oe_n, .user_ready_b,
    .interface_ready_output_b, .port_b_data_buffer, .port_b_data_out,
    .port_b_data_oe_n);
  group1_ctl_model ctl_u (.mclk, .rst_n, .ctl_req, .ctl_status, .ctl_rdata);
  task automatic complete_run;
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one access; the request drops after the take edge, the answer is awaited
  task automatic acc(input logic w, input logic a, input logic [1:0] be,
                     input logic [15:0] d);
    int i;
    // a fetch in progress would refuse the request, so let it end first
    for (i = 0; i < 4 && host_busy !== 1'b0; i++) @(posedge mclk) #1;
    host_req = '{1'b1, w, !w, a, be, d};
    @(posedge mclk);
    #1 host_req.sel = 1'b0;
    for (i = 0; i < 4 && host_ack !== 1'b1; i++) @(posedge mclk) #1;
    if (host_ack !== 1'b1) begin
      miscompares++;
      complete_run;
    end
    @(posedge mclk) #1;
  endtask : acc
  task automatic wr(input logic a, input logic [1:0] be, input logic [15:0] d);
    acc(1'b1, a, be, d);
  endtask : wr
  task automatic rd(input logic a, input logic [15:0] exp);
    acc(1'b0, a, 2'b00, 16'h0000);
    chk(host_rdata, exp);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  // 20 ns clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // reset, then register, pin and interrupt checks
  initial begin
    host_req = '0;
    rst_n = 1'b0;
    bus_initialize = 1'b0;
    grp1_irq_req = 1'b1;
    grp2_irq_req = 1'b0;
    user_ready_a = 1'b0;
    user_ready_b = 1'b0;
    port_a_data_buffer = 16'h0f0f;
    port_b_data_buffer = 16'h1234;
    ext_req = 16'h0000;
    miscompares = 0;
    checked = 0;
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    rd(1'b0, 16'h0000);
    chk({15'h0000, interface_ready_output_a}, 16'h0001);
    wr(1'b0, 2'b11, 16'hffff);
    rd(1'b0, 16'h03ff);
    chk({15'h0000, proc_irq_req}, 16'h0001);
    chk({15'h0000, interface_ready_output_a}, 16'h0000);
    wr(1'b0, 2'b10, 16'h0000);
    rd(1'b0, 16'h00ff);
    grp1_irq_req = 1'b0;
    grp2_irq_req = 1'b1;
    cyc(1);
    chk({15'h0000, proc_irq_req}, 16'h0000);
    // select register 3, fill 3 and 4, reselect 3 and read it back
    wr(1'b0, 2'b01, 16'h0003);
    wr(1'b1, 2'b01, 16'h005a);
    wr(1'b0, 2'b01, 16'h0004);
    wr(1'b1, 2'b01, 16'h00a5);
    wr(1'b0, 2'b01, 16'h0003);
    rd(1'b1, 16'h005a);
    wr(1'b1, 2'b11, 16'hff5a);
    rd(1'b1, 16'h015a);
    user_ready_a = 1'b1;
    user_ready_b = 1'b1;
    cyc(5);
    chk({15'h0000, port_b_data_oe_n}, 16'h0000);
    chk(port_b_data_out, 16'h1234);
    chk({15'h0000, port_a_data_oe_n}, 16'h0001);
    chk(port_a_data_out, 16'h0f0f);
    rd(1'b1, 16'h815a);
    user_ready_b = 1'b0;
    cyc(5);
    chk({15'h0000, port_b_data_oe_n}, 16'h0001);
    user_ready_b = 1'b1;
    wr(1'b0, 2'b10, 16'h0200);
    chk({15'h0000, proc_irq_req}, 16'h0001);
    bus_initialize = 1'b1;
    cyc(4);
    bus_initialize = 1'b0;
    cyc(3);
    rd(1'b0, 16'h8003);
    rd(1'b1, 16'h805a);
    ext_req = 16'ha5c3;
    cyc(3);
    chk(ext_req_sync, 16'ha5c3);
    complete_run;
  end
endmodule : testbench
bind port_csr_group1 port_csr_group1_sva chk_u (.mclk, .rst_n,
  .bus_initialize, .host_req, .host_busy, .host_ack, .host_rdata, .ctl_req,
  .grp1_irq_req, .grp2_irq_req, .proc_irq_req, .user_ready_b,
  .interface_ready_output_a, .interface_ready_output_b, .port_b_data_oe_n);
